// file: src/xdc_pkg.sv
// constants, timing and carrier types for the held-output memory controller
// assumes a 100 MHz controller clock; all times are in ns
package xdc_pkg;
    // =========================================================
    // geometry
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    localparam int PIN_W = 12;
    localparam int ROW_BITS_4K = 12;
    // =========================================================
    // times as printed, and cycle counts derived from them
    localparam int CLK_NS = 10;
    localparam int RAC_NS = 60;
    localparam int CAC_NS = 15;
    localparam int AA_NS = 30;
    localparam int PAGE_NS = 25;
    localparam int RCD_NS = 20;
    localparam int RP_NS = 40;
    localparam int CSR_NS = 10;
    localparam int RASP_NS = 10000;
    localparam int REF_WIN_NS = 64000000;
    localparam int INIT_PAUSE_NS = 200000;
    localparam int INIT_CYCLES = 8;
    localparam int CW = 16;

    function automatic int cyc_up(input int ns);
        return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1
            : (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    function automatic int cyc_dn(input int ns);
        return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
    endfunction

    localparam int RAC_CYC = cyc_up(RAC_NS);
    localparam int CAS_CYC = (cyc_up(AA_NS) > cyc_up(CAC_NS))
        ? cyc_up(AA_NS) : cyc_up(CAC_NS);
    localparam int PAGE_CYC = cyc_up(PAGE_NS);
    localparam int RCD_CYC = cyc_up(RCD_NS);
    localparam int RP_CYC = cyc_up(RP_NS);
    localparam int CSR_CYC = cyc_up(CSR_NS);
    localparam int RASP_CYC = cyc_dn(RASP_NS);
    localparam int INIT_CYC = cyc_up(INIT_PAUSE_NS);
    // set-up, low, gate-off and high cycles of one column access
    localparam int COL_SPAN_CYC = CAS_CYC + 3;
    // =========================================================
    // carriers
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } xdc_req_type;

    typedef struct packed {
        logic row_strobe_n;
        logic col_strobe_n;
        logic write_sel_n;
        logic out_gate_n;
    } xdc_strobe_type;

    typedef enum logic [9:0] {
        ST_INIT = 10'h001,
        ST_IDLE = 10'h002,
        ST_RSET = 10'h004,
        ST_RACT = 10'h008,
        ST_CSET = 10'h010,
        ST_CLOW = 10'h020,
        ST_CEND = 10'h040,
        ST_CHIGH = 10'h080,
        ST_PRE = 10'h100,
        ST_RFSET = 10'h200
    } xdc_state_type;
endpackage

// file: src/xdc_ctrl.sv
// host-side controller for a 2M x 8 held-output dynamic memory
// assumes the memory pins are registered straight out of this block
// What this block does
// - each byte is chosen by 21 address bits, row then column on shared pins
// - 4096-row part: 12 row bits on pins 0-11, 9 column bits on 0-8
// - 2048-row part: 11 row bits on pins 0-10, 10 column bits on 0-9
// - address pins stable before row strobe fall and column strobe fall
// - random columns in one open row, limited by maximum row-active time
// - gate raised before column rise and held after floats data till next fall
// - gate pulse during column-high time floats data till column falls; not used here, the gate rises in ST_CEND
// - 4096-row part needs every row refreshed within 64 ms
// - 2048-row part needs all rows refreshed within 32 ms
// - row-only refresh: row strobe cycles, column high, address supplied
// - hidden refresh: column held low after read while row strobe cycles; not used here
// - column fall before row fall, held low after, refreshes internal row
// - after power-up wait 200 us, then eight cycles including a refresh
// - page column cycles no shorter than 25 ns
`timescale 1ns/1ps
module xdc_ctrl
    import xdc_pkg::*;
#(
    parameter int ROW_BITS = ROW_BITS_4K,
    parameter int INIT_WAIT_CYC = INIT_CYC,
    parameter int REF_INT_CYC = REF_WIN_NS / (1 << ROW_BITS_4K) / CLK_NS,
    parameter bit ROW_ONLY_REFRESH = 1'b0
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire xdc_pkg::xdc_req_type req,
    input wire logic req_valid,
    output logic req_ready,
    output logic [xdc_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic init_done,
    output xdc_pkg::xdc_strobe_type strobes,
    output logic [xdc_pkg::PIN_W-1:0] mux_address_pins,
    output logic [xdc_pkg::DATA_W-1:0] data_pins_o,
    output logic data_pins_oe,
    input wire logic [xdc_pkg::DATA_W-1:0] data_pins_i
);
    import xdc_pkg::*;
    localparam int COL_BITS = ADDR_W - ROW_BITS;

    // =========================================================
    // state and bookkeeping
    xdc_state_type state_reg, state_next;
    xdc_req_type cur_reg, cur_view;
    logic pend_reg, pend_next, take, page_ok, same_row, ref_start, ref_end;
    logic ref_pend_reg, ready_next;
    logic [CW-1:0] cnt_reg, cnt_next, ras_age_reg, ref_cnt_reg;
    logic [3:0] init_left_reg;
    logic [ROW_BITS-1:0] ref_row_reg;
    xdc_strobe_type pins_next;
    logic [PIN_W-1:0] addr_next;
    logic oe_next;

    assign take = req_valid & req_ready;
    assign cur_view = take ? req : cur_reg;
    assign same_row = req.addr[ADDR_W-1:COL_BITS]
        == cur_reg.addr[ADDR_W-1:COL_BITS];
    // keep a full column access worth of margin below the row limit
    assign page_ok = (ras_age_reg < CW'(RASP_CYC - COL_SPAN_CYC))
        && !ref_pend_reg;
    assign ref_start = (state_next == ST_RFSET) && (state_reg != ST_RFSET);
    assign ref_end = (state_reg == ST_RFSET) && (cnt_reg == '0)
        && !strobes.row_strobe_n;

    // next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_INIT:
                if (cnt_reg == '0)
                    state_next = ST_IDLE;
            ST_IDLE:
                if (ref_pend_reg || init_left_reg != '0)
                    state_next = ST_RFSET;
                else if (pend_reg || take)
                    state_next = ST_RSET;
            ST_RSET:
                state_next = ST_RACT;
            ST_RACT:
                if (cnt_reg == '0)
                    state_next = ST_CSET;
            ST_CSET:
                state_next = ST_CLOW;
            ST_CLOW:
                if (cnt_reg == '0 && ras_age_reg >= CW'(RAC_CYC))
                    state_next = ST_CEND;
            ST_CEND:
                state_next = ST_CHIGH;
            ST_CHIGH:
                if (take)
                    state_next = (same_row && page_ok) ? ST_CSET : ST_PRE;
                else if (!page_ok)
                    state_next = ST_PRE;
            ST_PRE:
                if (cnt_reg == '0)
                    state_next = ST_IDLE;
            ST_RFSET:
                if (ref_end)
                    state_next = ST_PRE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // duration of each timed state, loaded on entry
    always_comb
    begin
        cnt_next = (cnt_reg == '0) ? '0 : cnt_reg - 1'b1;
        if (state_next != state_reg || ref_start)
        begin
            case (state_next)
                ST_RACT: cnt_next = CW'(RCD_CYC - 1);
                ST_CLOW: cnt_next = CW'(CAS_CYC - 1);
                ST_PRE: cnt_next = CW'(RP_CYC - 1);
                ST_RFSET: cnt_next = CW'(CSR_CYC + RAC_CYC - 1);
                default: cnt_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_INIT;
            cnt_reg <= CW'(INIT_WAIT_CYC - 1);
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // =========================================================
    // request capture; a page miss is held over the precharge
    always_comb
    begin
        pend_next = pend_reg;
        if (take)
            pend_next = 1'b1;
        if (state_next == ST_CSET)
            pend_next = 1'b0;
    end

    assign ready_next = (state_next == ST_IDLE && !pend_next
        && init_left_reg == '0 && !ref_pend_reg)
        || (state_next == ST_CHIGH && page_ok && !take);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_reg <= '0;
            pend_reg <= 1'b0;
            req_ready <= 1'b0;
        end
        else
        begin
            cur_reg <= cur_view;
            pend_reg <= pend_next;
            req_ready <= ready_next;
        end
    end

    // time since the row strobe fell, for access and row-limit checks
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ras_age_reg <= '0;
        else if (strobes.row_strobe_n)
            ras_age_reg <= '0;
        else if (ras_age_reg != '1)
            ras_age_reg <= ras_age_reg + 1'b1;
    end

    // =========================================================
    // refresh pacing; a new tick wins over the clear by a start
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_cnt_reg <= '0;
            ref_pend_reg <= 1'b0;
            ref_row_reg <= '0;
            init_left_reg <= 4'(INIT_CYCLES);
            init_done <= 1'b0;
        end
        else
        begin
            ref_cnt_reg <= (ref_cnt_reg == '0) ? CW'(REF_INT_CYC - 1)
                : ref_cnt_reg - 1'b1;
            ref_pend_reg <= (ref_cnt_reg == '0)
                || (ref_pend_reg && !ref_start);
            if (ref_end)
            begin
                ref_row_reg <= ref_row_reg + 1'b1;
                if (init_left_reg != '0)
                    init_left_reg <= init_left_reg - 1'b1;
            end
            init_done <= (init_left_reg == '0);
        end
    end

    // =========================================================
    // pin values per state, registered so every pin is a flop
    always_comb
    begin
        pins_next = '{1'b1, 1'b1, 1'b1, 1'b1};
        addr_next = '0;
        oe_next = 1'b0;
        case (state_next)
            ST_RSET, ST_RACT:
            begin
                pins_next.row_strobe_n = (state_next == ST_RSET);
                addr_next = PIN_W'(cur_view.addr[ADDR_W-1:COL_BITS]);
            end
            ST_CSET, ST_CLOW, ST_CEND:
            begin
                // write select drops a cycle ahead of the column strobe,
                // so the memory never drives during our write
                pins_next.row_strobe_n = 1'b0;
                pins_next.col_strobe_n = (state_next == ST_CSET);
                pins_next.write_sel_n = !cur_view.write;
                pins_next.out_gate_n = cur_view.write
                    || state_next != ST_CLOW;
                addr_next = PIN_W'(cur_view.addr[COL_BITS-1:0]);
                oe_next = cur_view.write;
            end
            ST_CHIGH:
                pins_next.row_strobe_n = 1'b0;
            ST_RFSET:
            begin
                // column-first unless row-only refresh is chosen; the
                // hidden form is not used since reads end with gate off
                pins_next.col_strobe_n = ROW_ONLY_REFRESH;
                pins_next.row_strobe_n = cnt_reg > CW'(RAC_CYC)
                    && state_reg != ST_RFSET || ref_start;
                addr_next = PIN_W'(ref_row_reg);
            end
            default:
                pins_next = '{1'b1, 1'b1, 1'b1, 1'b1};
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobes <= '{1'b1, 1'b1, 1'b1, 1'b1};
            mux_address_pins <= '0;
            data_pins_o <= '0;
            data_pins_oe <= 1'b0;
        end
        else
        begin
            strobes <= pins_next;
            mux_address_pins <= addr_next;
            data_pins_o <= cur_view.wdata;
            data_pins_oe <= oe_next;
        end
    end

    // read data is taken at the last ST_CLOW cycle, before the gate rises in ST_CEND
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= '0;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= state_reg == ST_CLOW && state_next == ST_CEND
                && !cur_reg.write;
            if (state_reg == ST_CLOW && state_next == ST_CEND)
                rd_data <= data_pins_i;
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic [CW-1:0] pend_age_reg;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pend_age_reg <= '0;
        else
            pend_age_reg <= (ref_pend_reg && state_reg != ST_INIT)
                ? pend_age_reg + 1'b1 : '0; // power-up pause is exempt
    end

    sequence s_col_first;
        !strobes.col_strobe_n && strobes.row_strobe_n;
    endsequence

    sequence s_row_fall;
        $fell(strobes.row_strobe_n) ##1 !strobes.col_strobe_n;
    endsequence

    a_addr_row_stable: assert property ($fell(strobes.row_strobe_n)
        |-> $stable(mux_address_pins)) else $error("row addr moved");
    a_addr_col_stable: assert property ($fell(strobes.col_strobe_n)
        && !strobes.row_strobe_n |-> $stable(mux_address_pins))
        else $error("col addr moved");
    a_early_write_order: assert property ($fell(strobes.col_strobe_n)
        && !strobes.write_sel_n |-> $past(!strobes.write_sel_n))
        else $error("write select late");
    a_gate_before_rise: assert property ($rose(strobes.col_strobe_n)
        && !strobes.row_strobe_n |-> $past(strobes.out_gate_n)
        && strobes.out_gate_n) else $error("gate not off");
    a_no_bus_clash: assert property (data_pins_oe |-> strobes.out_gate_n
        && !strobes.write_sel_n) else $error("bus clash");
    a_col_first_ref: assert property (!ROW_ONLY_REFRESH && ref_start
        |=> s_col_first ##1 s_row_fall) else $error("refresh order");
    a_row_limit_kept: assert property (!strobes.row_strobe_n
        |-> ras_age_reg < CW'(RASP_CYC)) else $error("row open too long");
    a_precharge_held: assert property ($rose(strobes.row_strobe_n)
        |-> strobes.row_strobe_n [*4]) else $error("short precharge");
    a_page_low_time: assert property ($fell(strobes.col_strobe_n)
        |-> !strobes.col_strobe_n [*3]) else $error("short column");
    a_read_access: assert property ($rose(rd_valid)
        |-> $past(ras_age_reg) >= CW'(RAC_CYC)) else $error("read early");
    a_refresh_served: assert property (pend_age_reg < CW'(REF_INT_CYC))
        else $error("refresh starved");
endmodule

// file: verif/xdc_mem_model.sv
// =====================================================
// pin-level model of the 2M x 8 held-output memory device
// assumes the bench resolves the shared data pins into data_pins_i
`timescale 1ns/1ps
module xdc_mem_model
    import xdc_pkg::*;
#(
    parameter int ROW_BITS = ROW_BITS_4K
)
(
    input wire logic row_n,
    input wire logic col_n,
    input wire logic wr_n,
    input wire logic gate_n,
    input wire logic [xdc_pkg::PIN_W-1:0] mux_address_pins,
    input wire logic [xdc_pkg::DATA_W-1:0] data_pins_i,
    output logic [xdc_pkg::DATA_W-1:0] data_pins_o,
    output logic data_pins_oe,
    output int ref_cnt,
    output int viol
);
    localparam int CB = ADDR_W - ROW_BITS;
    // =====================================================
    // storage and pin state
    logic [DATA_W-1:0] mem [int];
    logic [ADDR_W-1:0] a_q = '0;
    logic [PIN_W-1:0] row_q = '0;
    logic ok = 1'b0;
    logic off = 1'b0;
    logic early = 1'b0;
    logic ron = 1'b0;
    realtime t_rf = 0;
    realtime t_rr = 0;
    realtime t_cf = -100;
    realtime t_a = 0;
    realtime d;
    initial
    begin
        ref_cnt = 0;
        viol = 0;
        data_pins_o = '0;
    end
    // last address change, to catch late address set-up
    always @(mux_address_pins) t_a = $realtime;
    // output survives column rise; gate, write or float latch cut it
    assign data_pins_oe = ok && !off && !early && !gate_n && wr_n;
    // =====================================================
    // row strobe: open row, or internal refresh if column is low
    always @(negedge row_n)
    begin
        if (t_rr > 0 && $realtime - t_rr < RP_NS) viol++;
        t_rf = $realtime;
        ok = 1'b0;
        ron = col_n; // row-only refresh unless a column follows
        if (!col_n) ref_cnt++;
        else
        begin
            if (t_a >= $realtime) viol++;
            row_q = mux_address_pins;
        end
    end
    always @(posedge row_n)
    begin
        if ($realtime - t_rf > RASP_NS) viol++;
        if (ron) ref_cnt++;
        t_rr = $realtime;
    end
    // =====================================================
    // column strobe: latch column, write or launch read data
    always @(negedge col_n)
    begin
        if (!row_n)
        begin
            if (t_a >= $realtime) viol++;
            if ($realtime - t_cf < PAGE_NS) viol++;
            t_cf = $realtime;
            a_q = {row_q[ROW_BITS-1:0], mux_address_pins[CB-1:0]};
            off = 1'b0;
            ok = 1'b0;
            early = !wr_n;
            ron = 1'b0;
            if (!wr_n) mem[a_q] = data_pins_i;
            else
            begin
                data_pins_o = mem.exists(a_q) ? mem[a_q]
                    : a_q[7:0] ^ a_q[20:13];
                // slowest of the three access paths wins
                d = CAC_NS;
                if (RAC_NS - ($realtime - t_rf) > d) d = RAC_NS - ($realtime - t_rf);
                if (AA_NS - ($realtime - t_a) > d) d = AA_NS - ($realtime - t_a);
                ok <= #(d) 1'b1;
            end
        end
    end
    // late write select fall captures data; in column-high it floats
    always @(negedge wr_n)
    begin
        if (!col_n && !row_n) mem[a_q] = data_pins_i;
        else off = 1'b1;
    end
    // gate high across column rise, or a gate pulse in column-high
    always @(posedge col_n) if (gate_n) off = 1'b1;
    always @(posedge gate_n) if (col_n) off = 1'b1;
endmodule

// file: verif/xdc_ctrl_tb.sv
// =====================================================
// self-checking bench for the held-output memory controller
// assumes xdc_mem_model on the memory pins; short init and refresh
`timescale 1ns/1ps
module xdc_ctrl_tb;
    import xdc_pkg::*;
    localparam int INIT_W = 20;
    localparam int REF_I = 200;
    // =====================================================
    // signals
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_ready, rd_valid, init_done, oe, mem_oe;
    xdc_req_type req = '0;
    xdc_strobe_type strobes;
    logic [DATA_W-1:0] rd_data, dpo, mem_do, dq;
    logic [DATA_W-1:0] last_dq = '0;
    logic [PIN_W-1:0] apins;
    logic [ADDR_W-1:0] a;
    logic init_done_b;
    xdc_strobe_type strobes_b;
    logic [PIN_W-1:0] apins_b;
    logic [PIN_W-1:0] rows [4] = '{12'h000, 12'h001, 12'h7ff, 12'hfff};
    logic [DATA_W-1:0] shadow [int];
    int failures = 0;
    int cmp_count = 0;
    int seed = 2781;
    int i, n, r0, ref_cnt, viol, ref_cnt_b, viol_b;
    realtime t_rel = 0;
    realtime t_first = 0;
    always #5 ref_clk = ~ref_clk;
    // released line shows the inverse of its last driven value
    assign dq = oe ? dpo : mem_oe ? mem_do : ~last_dq;
    always @(dq) if (oe | mem_oe) last_dq = dq;
    always @(negedge strobes.row_strobe_n)
        if (rst_n && t_first == 0) t_first = $realtime;
    xdc_ctrl #(.INIT_WAIT_CYC(INIT_W), .REF_INT_CYC(REF_I)) i_xdc_ctrl (
        .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .init_done(init_done), .strobes(strobes), .mux_address_pins(apins),
        .data_pins_o(dpo), .data_pins_oe(oe), .data_pins_i(dq));
    xdc_mem_model i_xdc_mem_model (
        .row_n(strobes.row_strobe_n), .col_n(strobes.col_strobe_n),
        .wr_n(strobes.write_sel_n), .gate_n(strobes.out_gate_n),
        .mux_address_pins(apins), .data_pins_i(dq), .data_pins_o(mem_do),
        .data_pins_oe(mem_oe), .ref_cnt(ref_cnt), .viol(viol));
    // second pair: 2048-row part with row-only refresh, no requests
    xdc_ctrl #(.ROW_BITS(11), .INIT_WAIT_CYC(INIT_W), .REF_INT_CYC(REF_I),
        .ROW_ONLY_REFRESH(1'b1)) i_xdc_ctrl_b (
        .ref_clk(ref_clk), .rst_n(rst_n), .req('0), .req_valid(1'b0),
        .req_ready(), .rd_data(), .rd_valid(), .init_done(init_done_b),
        .strobes(strobes_b), .mux_address_pins(apins_b), .data_pins_o(),
        .data_pins_oe(), .data_pins_i(8'h00));
    xdc_mem_model #(.ROW_BITS(11)) i_xdc_mem_model_b (
        .row_n(strobes_b.row_strobe_n), .col_n(strobes_b.col_strobe_n),
        .wr_n(strobes_b.write_sel_n), .gate_n(strobes_b.out_gate_n),
        .mux_address_pins(apins_b), .data_pins_i(8'h00), .data_pins_o(),
        .data_pins_oe(), .ref_cnt(ref_cnt_b), .viol(viol_b));
    // =====================================================
    // tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("compares=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // untouched bytes read back the model's fill pattern
    function automatic logic [7:0] exp_rd(input logic [20:0] ad);
        return shadow.exists(ad) ? shadow[ad] : ad[7:0] ^ ad[20:13];
    endfunction
    // one request, held until taken; reads wait for the data pulse
    task automatic xfer(input logic w, input logic [20:0] ad,
        input logic [7:0] d);
        int k;
        @(negedge ref_clk);
        req = '{write: w, addr: ad, wdata: d};
        req_valid = 1'b1;
        k = 0;
        while (req_ready !== 1'b1 && k < 3000)
        begin
            @(negedge ref_clk);
            k++;
        end
        check(8'(k < 3000), 8'h01);
        @(negedge ref_clk);
        req_valid = 1'b0;
        if (w) shadow[ad] = d;
        else
        begin
            k = 0;
            while (rd_valid !== 1'b1 && k < 50)
            begin
                @(negedge ref_clk);
                k++;
            end
            check(8'(k < 50), 8'h01);
            check(rd_data, exp_rd(ad));
        end
    endtask
    // =====================================================
    // main sequence
    initial
    begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        t_rel = $realtime;
        n = 0;
        while (init_done !== 1'b1 && n < 2000)
        begin
            @(negedge ref_clk);
            n++;
        end
        check(8'(init_done), 8'h01);
        check(8'(ref_cnt >= INIT_CYCLES), 8'h01);
        check(8'(t_first >= t_rel + INIT_W * CLK_NS), 8'h01);
        // corner addresses, then back-to-back write and read in one row
        xfer(1'b1, 21'h000000, 8'h5a);
        xfer(1'b1, 21'h1fffff, 8'ha5);
        xfer(1'b0, 21'h000000, 8'h00);
        xfer(1'b0, 21'h1fffff, 8'h00);
        xfer(1'b0, 21'h1ffffe, 8'h00);
        xfer(1'b1, 21'h1ffffe, 8'h3c);
        xfer(1'b0, 21'h1ffffe, 8'h00);
        // random mix over a few rows gives page hits and misses
        for (i = 0; i < 150; i++)
        begin
            a = {rows[$random(seed) & 3], 9'($random(seed))};
            xfer(1'($random(seed)), a, 8'($random(seed)));
        end
        // idle stretch: only refresh may run
        r0 = ref_cnt;
        repeat (2000) @(negedge ref_clk);
        check(8'(ref_cnt - r0 >= 2000 / REF_I - 2), 8'h01);
        check(8'(viol == 0), 8'h01);
        // the second pair has refreshed all along, by row strobe only
        check(8'(init_done_b), 8'h01);
        check(8'(ref_cnt_b >= INIT_CYCLES + 2000 / REF_I), 8'h01);
        check(8'(viol_b == 0), 8'h01);
        close_out;
    end
    // hang guard, well past the expected run length
    initial
    begin
        #(600000);
        failures++;
        close_out;
    end
endmodule
